// ---- hdl/irq_arbiter.v ----
// Two-level fixed-order arbiter over the gated request vector
`timescale 1ns/1ns
`include "irq_handler_regs.vh"
module irq_arbiter (
  input wire [18:0] request,
  input wire [18:0] priority_high,
  input wire block_low,
  input wire block_high,
  output reg found,
  output reg found_high,
  output reg [4:0] winner
);
  integer i;
  reg [18:0] high_req;
  reg [18:0] low_req;
  always @* begin
    high_req = request & priority_high & {19{~block_high}};
    low_req = request & ~priority_high & {19{~block_low}};
    found = 1'b0;
    found_high = 1'b0;
    winner = `IRQ_NONE_ID;
    // Highest index first so the lowest order number wins
    for (i = `IRQ_NUM_SRC - 1; i >= 0; i = i - 1) begin
      if (low_req[i]) begin
        found = 1'b1;
        winner = i[4:0];
      end
    end
    for (i = `IRQ_NUM_SRC - 1; i >= 0; i = i - 1) begin
      if (high_req[i]) begin
        found = 1'b1;
        found_high = 1'b1;
        winner = i[4:0];
      end
    end
  end
endmodule

// ---- hdl/irq_handler.v ----
// Two-level vectored interrupt handler for the CPU core
// Function
// - Valid condition sets pending; enables gate request
// - Pending sets regardless; disabled sources ignored
// - Long call after current instruction completes
// - Still pending after return: request again
// - Pins and timers A/B cleared on vectoring
// - Global enable bit gates every source
// - Software set acts like hardware event
// - One enable bit per source
// - One priority bit per source, same position
// - Priorities reset to low
// - High preempts low; nothing preempts high
// - Higher level first, then lowest order
// - Sample and decode requests every clock
// - One instruction runs after return first; a request already armed is not held
// - Worst-case response nineteen cycles
// - Equal or higher running routine blocks
// - Vector is 0x0003 plus eight times order
// - Multi-flag sources request on any flag
`timescale 1ns/1ns
`include "irq_handler_regs.vh"
module irq_handler (
  input wire clock,
  input wire rst_n,
  input wire enable_write,
  input wire [7:0] enable_wdata,
  input wire priority_write,
  input wire [7:0] priority_wdata,
  input wire ext_a_enable_write,
  input wire [7:0] ext_a_enable_wdata,
  input wire ext_a_priority_write,
  input wire [7:0] ext_a_priority_wdata,
  input wire ext_b_enable_write,
  input wire [7:0] ext_b_enable_wdata,
  input wire ext_b_priority_write,
  input wire [7:0] ext_b_priority_wdata,
  input wire [18:0] source_event,
  input wire [18:0] soft_set,
  input wire [18:0] soft_clear,
  input wire port_match_live,
  input wire instr_boundary,
  input wire return_from_interrupt,
  input wire vector_ack,
  output wire [7:0] main_irq_enable_reg,
  output wire [7:0] main_irq_priority_reg,
  output wire [7:0] ext_irq_enable_reg_a,
  output wire [7:0] ext_irq_enable_reg_b,
  output wire [7:0] ext_irq_priority_reg_a,
  output wire [7:0] ext_irq_priority_reg_b,
  output wire [18:0] pending,
  output wire irq_request,
  output reg long_call,
  output reg [15:0] long_call_addr,
  output reg [4:0] serviced_source,
  output reg [1:0] in_service
);

  // ************************************************
  // Vector arithmetic
  // ************************************************
  function [15:0] vector_of;
    input [4:0] order;
    begin
      vector_of = `IRQ_VEC_BASE + ({`IRQ_VEC_PAD, order} << `IRQ_VEC_SHIFT);
    end
  endfunction

  // Sources whose flag hardware clears on vectoring
  function auto_clears;
    input [4:0] order;
    begin
      auto_clears = (order == `IRQ_SRC_EXT0) || (order == `IRQ_SRC_TMR0) ||
        (order == `IRQ_SRC_EXT1) || (order == `IRQ_SRC_TMR1);
    end
  endfunction

  // ************************************************
  // Enable and priority registers
  // ************************************************
  reg [7:0] enable_main;
  reg [6:0] prio_main;
  reg [7:0] enable_a;
  reg [7:0] prio_a;
  reg [3:0] enable_b;
  reg [3:0] prio_b;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enable_main <= `IRQ_ENABLE_RESET;
      prio_main <= `IRQ_PRIO_MAIN_RESET;
      enable_a <= `IRQ_ENABLE_RESET;
      prio_a <= `IRQ_PRIO_RESET;
      enable_b <= `IRQ_EXTB_RESET;
      prio_b <= `IRQ_EXTB_RESET;
    end else begin
      if (enable_write) begin
        enable_main <= enable_wdata;
      end
      if (priority_write) begin
        prio_main <= priority_wdata[6:0];
      end
      if (ext_a_enable_write) begin
        enable_a <= ext_a_enable_wdata;
      end
      if (ext_a_priority_write) begin
        prio_a <= ext_a_priority_wdata;
      end
      if (ext_b_enable_write) begin
        enable_b <= ext_b_enable_wdata[3:0];
      end
      if (ext_b_priority_write) begin
        prio_b <= ext_b_priority_wdata[3:0];
      end
    end
  end
  // Unused top bit of main priority reads as one
  assign main_irq_enable_reg = enable_main;
  assign main_irq_priority_reg = {1'b1, prio_main};
  assign ext_irq_enable_reg_a = enable_a;
  assign ext_irq_priority_reg_a = prio_a;
  assign ext_irq_enable_reg_b = {4'h0, enable_b};
  assign ext_irq_priority_reg_b = {4'h0, prio_b};

  wire global_irq_enable = enable_main[`IRQ_GLOBAL_BIT];
  wire [18:0] source_enable = {enable_b, enable_a, enable_main[6:0]};
  wire [18:0] source_high = {prio_b, prio_a, prio_main};

  // ************************************************
  // Pending flags
  // ************************************************
  // Source_event is the OR of each source's own flags
  reg [18:0] pend;
  reg [1:0] vec_state;
  wire found;
  wire found_high;
  wire [4:0] winner;
  wire take_vector;
  reg [18:0] hw_clear;
  integer k;
  // Clear the source actually vectored, not an older winner
  always @* begin
    hw_clear = `IRQ_PEND_RESET;
    for (k = 0; k < `IRQ_NUM_SRC; k = k + 1) begin
      if (take_vector && winner == k[4:0] && auto_clears(winner)) begin
        hw_clear[k] = 1'b1;
      end
    end
  end
  reg [18:0] next_pend;
  always @* begin
    // Set wins over any clear in the same cycle
    next_pend = (pend & ~soft_clear & ~hw_clear) | source_event | soft_set;
    next_pend[`IRQ_SRC_PORT_MATCH] = 1'b0;
  end
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pend <= `IRQ_PEND_RESET;
    end else begin
      pend <= next_pend;
    end
  end
  wire [18:0] live_pend = pend | ({`IRQ_PM_PAD, port_match_live} << `IRQ_SRC_PORT_MATCH);
  assign pending = live_pend;

  // Disabled sources vanish from arbitration
  wire [18:0] gated = live_pend & source_enable & {19{global_irq_enable}};

  // ************************************************
  // Arbitration
  // ************************************************
  reg hold_after_return;
  irq_arbiter arbiter (
    .request(gated),
    .priority_high(source_high),
    .block_low(in_service[0] | in_service[1]),
    .block_high(in_service[1]),
    .found(found),
    .found_high(found_high),
    .winner(winner)
  );
  assign irq_request = found & ~hold_after_return;

  // ************************************************
  // Vectoring sequence
  // ************************************************
  localparam idle = 2'b00;
  localparam armed = 2'b01;
  localparam calling = 2'b10;
  reg [1:0] next_vec_state;
  // A request is taken only at an instruction boundary
  assign take_vector = (vec_state == armed) & instr_boundary & found;
  always @* begin
    case (vec_state)
      idle: begin
        if (irq_request) begin
          next_vec_state = armed;
        end else begin
          next_vec_state = idle;
        end
      end
      armed: begin
        if (!found) begin
          next_vec_state = idle;
        end else if (instr_boundary) begin
          next_vec_state = calling;
        end else begin
          next_vec_state = armed;
        end
      end
      calling: begin
        if (vector_ack) begin
          next_vec_state = idle;
        end else begin
          next_vec_state = calling;
        end
      end
      default: begin
        next_vec_state = idle;
      end
    endcase
  end
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vec_state <= idle;
    end else begin
      vec_state <= next_vec_state;
    end
  end

  // ************************************************
  // Call request and vector
  // ************************************************
  // Winner is re-read at the boundary so a late higher request wins
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      long_call <= 1'b0;
      long_call_addr <= `IRQ_RESET_VEC;
      serviced_source <= `IRQ_NONE_ID;
    end else begin
      if (take_vector) begin
        long_call <= 1'b1;
        long_call_addr <= vector_of(winner);
        serviced_source <= winner;
      end else if (vector_ack) begin
        long_call <= 1'b0;
      end
    end
  end

  // ************************************************
  // In-service markers
  // ************************************************
  // Return ends the highest level in service
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      in_service <= `IRQ_MARK_RESET;
    end else begin
      if (return_from_interrupt) begin
        if (in_service[1]) begin
          in_service[1] <= 1'b0;
        end else begin
          in_service[0] <= 1'b0;
        end
      end
      if (take_vector) begin
        if (found_high) begin
          in_service[1] <= 1'b1;
        end else begin
          in_service[0] <= 1'b1;
        end
      end
    end
  end

  // ************************************************
  // Post-return hold
  // ************************************************
  // Holds off irq_request from a return until the next instruction boundary; take_vector ignores it
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_after_return <= 1'b0;
    end else if (return_from_interrupt) begin
      hold_after_return <= 1'b1;
    end else if (instr_boundary) begin
      hold_after_return <= 1'b0;
    end
  end

endmodule

// ---- hdl/irq_handler_regs.vh ----
// Constants for the two-level vectored interrupt handler
`ifndef IRQ_HANDLER_REGS_VH
`define IRQ_HANDLER_REGS_VH
`define IRQ_NUM_SRC 19
`define IRQ_GLOBAL_BIT 7
`define IRQ_MAIN_SRC_COUNT 7
`define IRQ_EXTA_BASE 7
`define IRQ_EXTB_BASE 15
`define IRQ_EXTB_WIDTH 4
`define IRQ_SRC_EXT0 5'h00
`define IRQ_SRC_TMR0 5'h01
`define IRQ_SRC_EXT1 5'h02
`define IRQ_SRC_TMR1 5'h03
`define IRQ_SRC_PORT_MATCH 16
`define IRQ_VEC_BASE 16'h0003
`define IRQ_VEC_SHIFT 3
`define IRQ_RESET_VEC 16'h0000
`define IRQ_ENABLE_RESET 8'h00
`define IRQ_PRIO_RESET 8'h00
`define IRQ_NONE_ID 5'h1f
`define IRQ_PRIO_MAIN_RESET 7'h00
`define IRQ_EXTB_RESET 4'h0
`define IRQ_PEND_RESET 19'h00000
`define IRQ_VEC_PAD 11'h000
`define IRQ_PM_PAD 18'h00000
`define IRQ_MARK_RESET 2'b00
`endif

// ---- tb/cpu_model.sv ----
// Core sequencer model: instruction ends, call length, returns
`timescale 1ns/1ns
module cpu_model (
  input wire clock,
  input wire rst_n,
  input wire slow,
  input wire ret_req,
  input wire long_call,
  output reg instr_boundary,
  output reg vector_ack,
  output reg return_from_interrupt
);
  reg [2:0] c;
  reg [2:0] k;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      c <= 3'h0;
      k <= 3'h0;
      instr_boundary <= 1'b0;
      vector_ack <= 1'b0;
      return_from_interrupt <= 1'b0;
    end else begin
      c <= c + 3'h1;
      k <= (long_call && !vector_ack) ? k + 3'h1 : 3'h0;
      instr_boundary <= !long_call && (!slow || c == 3'h7);
      vector_ack <= long_call && !vector_ack && k == 3'h3;
      return_from_interrupt <= ret_req;
    end
  end
endmodule

// ---- tb/irq_handler_properties.sv ----
// Port assertions for the vectored interrupt handler
`timescale 1ns/1ns
module irq_handler_properties (
  input wire clock,
  input wire rst_n,
  input wire [18:0] source_event,
  input wire [18:0] soft_set,
  input wire instr_boundary,
  input wire return_from_interrupt,
  input wire vector_ack,
  input wire [7:0] main_irq_enable_reg,
  input wire [7:0] ext_irq_enable_reg_a,
  input wire [7:0] ext_irq_enable_reg_b,
  input wire [18:0] pending,
  input wire irq_request,
  input wire long_call,
  input wire [15:0] long_call_addr,
  input wire [4:0] serviced_source,
  input wire [1:0] in_service
);
  wire [18:0] en;
  assign en = {ext_irq_enable_reg_b[3:0], ext_irq_enable_reg_a, main_irq_enable_reg[6:0]};
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_gate;
    irq_request |-> main_irq_enable_reg[7] && (pending & en) != 19'h0;
  endproperty
  a_gate: assert property (p_gate) else $error("gate");
  property p_addr;
    $rose(long_call) |-> long_call_addr == 16'h0003 + {8'h00, serviced_source, 3'h0};
  endproperty
  a_addr: assert property (p_addr) else $error("addr");
  property p_bound;
    $rose(long_call) |-> $past(instr_boundary);
  endproperty
  a_bound: assert property (p_bound) else $error("bound");
  property p_stand;
    long_call && !vector_ack |=> long_call;
  endproperty
  a_stand: assert property (p_stand) else $error("stand");
  property p_clr;
    $rose(long_call) && serviced_source < 5'h04 && $past(soft_set | source_event) == 19'h0
      |-> !pending[serviced_source];
  endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_high;
    $rose(long_call) |-> !$past(in_service[1]);
  endproperty
  a_high: assert property (p_high) else $error("high");
  property p_mark;
    $rose(long_call) |-> in_service != $past(in_service);
  endproperty
  a_mark: assert property (p_mark) else $error("mark");
  property p_hold;
    return_from_interrupt |=> !irq_request;
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
endmodule
bind irq_handler irq_handler_properties u_props (.clock(clock), .rst_n(rst_n),
  .source_event(source_event), .soft_set(soft_set), .instr_boundary(instr_boundary),
  .return_from_interrupt(return_from_interrupt), .vector_ack(vector_ack),
  .main_irq_enable_reg(main_irq_enable_reg), .ext_irq_enable_reg_a(ext_irq_enable_reg_a),
  .ext_irq_enable_reg_b(ext_irq_enable_reg_b), .pending(pending), .irq_request(irq_request),
  .long_call(long_call), .long_call_addr(long_call_addr),
  .serviced_source(serviced_source), .in_service(in_service));

// ---- tb/two_level_vectored_irq_handler_bench.sv ----
// Self-checking bench for the vectored interrupt handler
`timescale 1ns/1ns
module two_level_vectored_irq_handler_bench;
  reg clock, rst_n, pml, slow, ret_req;
  reg [5:0] we;
  reg [7:0] wd;
  reg [18:0] se, ss, sc, pend;
  wire ib, ack, rfi, irq, lc;
  wire [7:0] r0, r1, r2, r3, r4, r5;
  wire [18:0] pd;
  wire [15:0] la;
  wire [4:0] src;
  wire [1:0] ins;
  integer n_errors, tests_run, i;
  irq_handler u_dut (.clock(clock), .rst_n(rst_n), .enable_write(we[0]), .enable_wdata(wd),
    .priority_write(we[1]), .priority_wdata(wd), .ext_a_enable_write(we[2]),
    .ext_a_enable_wdata(wd), .ext_a_priority_write(we[3]), .ext_a_priority_wdata(wd),
    .ext_b_enable_write(we[4]), .ext_b_enable_wdata(wd), .ext_b_priority_write(we[5]),
    .ext_b_priority_wdata(wd), .source_event(se), .soft_set(ss), .soft_clear(sc),
    .port_match_live(pml), .instr_boundary(ib), .return_from_interrupt(rfi),
    .vector_ack(ack), .main_irq_enable_reg(r0), .main_irq_priority_reg(r1),
    .ext_irq_enable_reg_a(r2), .ext_irq_enable_reg_b(r3), .ext_irq_priority_reg_a(r4),
    .ext_irq_priority_reg_b(r5), .pending(pd), .irq_request(irq), .long_call(lc),
    .long_call_addr(la), .serviced_source(src), .in_service(ins));
  cpu_model u_cpu (.clock(clock), .rst_n(rst_n), .slow(slow), .ret_req(ret_req),
    .long_call(lc), .instr_boundary(ib), .vector_ack(ack), .return_from_interrupt(rfi));
  // ****
  // Tasks
  // ****
  task ck(input [31:0] nm, input [19:0] e, input [19:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wr(input integer k, input [7:0] d);
    begin
      @(posedge clock);
      we <= 6'h01 << k;
      wd <= d;
      @(posedge clock);
      we <= 6'h00;
      @(negedge clock);
    end
  endtask
  task hit(input [18:0] m, input [18:0] c);
    begin
      @(posedge clock);
      ss <= m;
      sc <= c;
      pml <= m[16];
      @(posedge clock);
      ss <= 19'h0;
      sc <= 19'h0;
    end
  endtask
  task vec(input [4:0] s);
    integer t;
    begin
      for (t = 0; t < 60 && lc !== 1'b1; t = t + 1) @(negedge clock);
      ck("addr", 16'h0003 + {s, 3'h0}, la);
      ck("src", s, src);
      for (t = 0; t < 20 && lc === 1'b1; t = t + 1) @(negedge clock);
    end
  endtask
  task ret;
    begin
      @(posedge clock);
      ret_req <= 1'b1;
      @(posedge clock);
      ret_req <= 1'b0;
      repeat (2) @(negedge clock);
    end
  endtask
  task summarize;
    begin
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    clock = 0;
    forever #20 clock = ~clock;
  end
  initial begin
    #400000;
    n_errors = n_errors + 1;
    summarize;
  end
  initial begin
    {rst_n, pml, slow, ret_req, we, wd, se, ss, sc} = 0;
    n_errors = 0;
    tests_run = 0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    ck("prio", 8'h80, r1);
    ck("prb", 0, {r4, r5});
    ck("src", 5'h1f, src);
    hit(19'h2, 0);
    wr(0, 8'h02);
    ck("pend", 19'h2, pd);
    ck("req", 0, irq);
    wr(0, 8'h82);
    ck("req", 1, irq);
    vec(1);
    ret;
    wr(2, 8'hff);
    wr(4, 8'hff);
    wr(0, 8'hff);
    ck("enb", 8'h0f, r3);
    for (i = 0; i < 19; i = i + 1) begin
      hit(19'h1 << i, 0);
      vec(i);
      ck("pend", i < 4 ? 0 : 19'h1 << i, pd);
      hit(0, 19'h1 << i);
      pml <= 1'b0;
      ret;
    end
    hit(19'h220, 0);
    vec(5);
    hit(0, 19'h20);
    ret;
    vec(9);
    hit(0, 19'h200);
    ret;
    wr(3, 8'h04);
    wr(1, 8'h01);
    wr(5, 8'hff);
    ck("prio", 8'h81, r1);
    ck("prb", 8'h0f, r5);
    hit(19'h220, 0);
    vec(9);
    repeat (12) @(negedge clock);
    ck("call", 0, lc);
    hit(0, 19'h200);
    ret;
    vec(5);
    hit(19'h200, 0);
    vec(9);
    ck("ins", 2'h3, ins);
    hit(0, 19'h220);
    ret;
    @(negedge clock);
    ck("ins", 2'h1, ins);
    ret;
    @(negedge clock);
    ck("ins", 2'h0, ins);
    @(posedge clock);
    slow <= 1'b1;
    se <= 19'h8;
    @(posedge clock);
    se <= 19'h0;
    vec(3);
    ret;
    repeat (20) @(posedge clock);
    summarize;
  end
endmodule
